// *** hdl/scbr_pkg.sv ***
// shared constants and types of the serial configuration readout
package scbr_pkg;

    // ********************************************************
    // clock and link timing
    // ********************************************************
    localparam int SYS_CLK_MHZ = 200;
    localparam int SYS_CLK_PERIOD_NS = 5;
    // shortest reset pulse that clears the address counter
    localparam int RESET_PULSE_NS = 60;
    localparam int RESET_PULSE_CYC =
        (RESET_PULSE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    // configuration clock limits
    localparam int CFG_CLK_FMAX_MHZ = 15;
    localparam int CFG_CLK_LOW_NS = 20;
    localparam int CFG_CLK_HIGH_NS = 20;
    localparam int CFG_CLK_PERIOD_CYC =
        (SYS_CLK_MHZ + CFG_CLK_FMAX_MHZ - 1) / CFG_CLK_FMAX_MHZ;
    localparam int CFG_CLK_LOW_CYC =
        (CFG_CLK_LOW_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int CFG_CLK_HALF_RAW = (CFG_CLK_PERIOD_CYC + 1) / 2;
    localparam int CFG_CLK_HALF_CYC = (CFG_CLK_HALF_RAW > CFG_CLK_LOW_CYC)
        ? CFG_CLK_HALF_RAW : CFG_CLK_LOW_CYC;

    // ********************************************************
    // memory size and reset values
    // ********************************************************
    localparam int MEM_BITS_DEFAULT = 4194304;
    localparam logic LINE_IDLE_LEVEL = 1'h1;
    localparam logic SELECT_N_RESET = 1'h1;
    localparam logic RESET_OE_N_RESET = 1'h1;
    localparam logic CFG_CLK_RESET = 1'h0;

    // ********************************************************
    // host sequencer states
    // ********************************************************
    typedef enum logic [4:0] {
        HOST_IDLE   = 5'h01,
        HOST_RESET  = 5'h02,
        HOST_LOAD   = 5'h04,
        HOST_FINISH = 5'h08,
        HOST_CLEAR  = 5'h10
    } scbr_host_state_t;

endpackage

// *** hdl/scbr_link_if.sv ***
// link wires between the configuration memory and the fpga loader
`timescale 1ns/1ps
interface scbr_link_if;
    logic configClock;
    logic resetOeN;
    logic fpgaConfigSelectN;
    logic serialProgramSelectN;
    logic dataOut;
    logic dataOe;
    logic cascadeSelectOutN;
    wire fpgaSerialDataIn;

    // undriven data line floats to the idle level
    assign fpgaSerialDataIn = dataOe ? dataOut : scbr_pkg::LINE_IDLE_LEVEL;

    modport memory (
        input configClock,
        input resetOeN,
        input fpgaConfigSelectN,
        input serialProgramSelectN,
        output dataOut,
        output dataOe,
        output cascadeSelectOutN
    );

    modport fpga (
        output configClock,
        output resetOeN,
        output fpgaConfigSelectN,
        output serialProgramSelectN,
        input fpgaSerialDataIn,
        input cascadeSelectOutN
    );
endinterface

// *** hdl/scbr_memory.sv ***
// configuration memory end: bit store and serial readout
//
// Behaviour
// - programming select held inactive high by system
// - reset/output-enable low restores default, restarts readout
// - fpga select and clock wired to memory
// - one new data bit per rising clock
// - each enabled rising clock edge but the last advances address counter; the last one ends the readout
// - fpga releases select after whole bitstream
// - after last bit: cascade low, driver off
// - low chip select enables data output driver
// - cascade output wires to next chip select
// - reset low clears every chained address counter
// - reset input may be tied inactive high
// - reset held low at least 60 ns
// - select inactive: stop counting, output off
// - counter cleared at power-up
`timescale 1ns/1ps
module scbr_memory #(
    parameter int MEM_BITS = scbr_pkg::MEM_BITS_DEFAULT,
    parameter int AW = $clog2(MEM_BITS)
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // link to the fpga or the upstream memory
    scbr_link_if.memory link,
    // bit store loading port
    input wire logic loadEn,
    input wire logic [AW-1:0] loadAddr,
    input wire logic loadData,
    // status
    output logic [AW-1:0] readAddr,
    output logic readoutActive,
    output logic readoutEnded
);

    // ********************************************************
    // storage
    // ********************************************************
    // no reset on the array: contents survive a readout restart
    logic memQ [MEM_BITS];

    always_ff @(posedge sys_clk) begin
        if (loadEn) begin
            memQ[loadAddr] <= loadData;
        end
    end

    // ********************************************************
    // link decode
    // ********************************************************
    logic [AW-1:0] addrQ;
    logic [AW-1:0] addrD;
    logic doneQ;
    logic doneD;
    logic dataQ;
    logic oeQ;
    logic endedQ;

    wire logic inReset;
    wire logic selected;
    wire logic serialMode;
    wire logic enabled;
    wire logic clkRise;
    wire logic countEn;
    wire logic lastBit;
    wire logic readBit;
    wire logic lastRise;

    assign inReset = ~link.resetOeN;
    assign selected = ~link.fpgaConfigSelectN;
    // programming mode low blocks the readout
    assign serialMode = link.serialProgramSelectN;
    assign enabled = ~inReset & selected & serialMode & ~doneQ;
    // edge seen one cycle late; data lags the counter by one more cycle,
    // so the loader still samples settled data
    scbr_rise_detect #(
        .IDLE_LEVEL(scbr_pkg::CFG_CLK_RESET)
    ) i_scbr_rise_detect (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .level(link.configClock),
        .rise(clkRise)
    );
    assign countEn = enabled & clkRise;
    assign lastBit = (addrQ == AW'(MEM_BITS - 1));
    assign readBit = memQ[addrQ];
    // the rise that takes the last stored bit
    assign lastRise = countEn & lastBit;

    // ********************************************************
    // address counter and end of store
    // ********************************************************
    always_comb begin
        addrD = addrQ;
        doneD = doneQ;
        if (inReset) begin
            addrD = '0;
            doneD = 1'b0;
        end else if (countEn) begin
            if (lastBit) begin
                doneD = 1'b1;
            end else begin
                addrD = addrQ + AW'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            addrQ <= '0;
        end else begin
            addrQ <= addrD;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            doneQ <= 1'b0;
        end else begin
            doneQ <= doneD;
        end
    end

    // ********************************************************
    // serial data and driver enable
    // ********************************************************
    // data follows the counter one cycle late; the clock half
    // period of several cycles hides that lag from the fpga
    // present addressed bit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dataQ <= scbr_pkg::LINE_IDLE_LEVEL;
        end else begin
            dataQ <= readBit;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            oeQ <= 1'b0;
        end else begin
            oeQ <= enabled & ~doneD;
        end
    end

    // one pulse per readout
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            endedQ <= 1'b0;
        end else begin
            endedQ <= lastRise;
        end
    end

    assign link.dataOut = dataQ;
    assign link.dataOe = oeQ;
    assign link.cascadeSelectOutN = ~doneQ;

    // ********************************************************
    // status
    // ********************************************************
    assign readAddr = addrQ;
    assign readoutActive = oeQ;
    assign readoutEnded = endedQ;

endmodule

// ********************************************************
// rising edge of a level sampled on the system clock
// ********************************************************
module scbr_rise_detect #(
    parameter logic IDLE_LEVEL = 1'h0
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // watched level and its edge
    input wire logic level,
    output logic rise
);

    logic prevQ;

    // reset to the idle level: no false edge after reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prevQ <= IDLE_LEVEL;
        end else begin
            prevQ <= level;
        end
    end

    assign rise = level & ~prevQ;

endmodule

// *** hdl/scbr_loader.sv ***
// fpga end: master serial loader driving the configuration memory
`timescale 1ns/1ps
module scbr_loader #(
    parameter int LOAD_BITS = scbr_pkg::MEM_BITS_DEFAULT,
    parameter bit CLEAR_AFTER = 1'b1,
    parameter int CW = $clog2(LOAD_BITS + 1)
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // link to the configuration memory
    scbr_link_if.fpga link,
    // user control
    input wire logic startReq,
    output logic busy,
    output logic loadDone,
    // received bitstream
    output logic bitValid,
    output logic bitData,
    output logic [CW-1:0] bitCount
);

    localparam int HW = $clog2(scbr_pkg::CFG_CLK_HALF_CYC + 1);
    localparam int RW = $clog2(scbr_pkg::RESET_PULSE_CYC + 1);

    scbr_pkg::scbr_host_state_t stateQ;
    scbr_pkg::scbr_host_state_t stateD;
    logic [RW-1:0] rstCntQ;
    logic [HW-1:0] halfCntQ;
    logic [CW-1:0] bitCntQ;
    logic clkQ;
    logic selNQ;
    logic rstNQ;
    logic bitValidQ;
    logic bitDataQ;
    logic doneQ;

    // ********************************************************
    // sequencing decode
    // ********************************************************
    wire logic rstEnd;
    wire logic halfEnd;
    wire logic riseNow;
    wire logic loadEnd;

    assign rstEnd = (rstCntQ == RW'(scbr_pkg::RESET_PULSE_CYC - 1));
    assign halfEnd = (halfCntQ == HW'(scbr_pkg::CFG_CLK_HALF_CYC - 1));
    assign riseNow = (stateQ == scbr_pkg::HOST_LOAD) & halfEnd & ~clkQ;
    // leave at the fall after the last rise, so the memory also
    // sees the clock edge of the final bit
    assign loadEnd = halfEnd & clkQ & (bitCntQ == CW'(LOAD_BITS));

    always_comb begin
        stateD = stateQ;
        unique case (stateQ)
            scbr_pkg::HOST_IDLE: begin
                if (startReq) begin
                    stateD = scbr_pkg::HOST_RESET;
                end
            end
            scbr_pkg::HOST_RESET: begin
                if (rstEnd) begin
                    stateD = scbr_pkg::HOST_LOAD;
                end
            end
            scbr_pkg::HOST_LOAD: begin
                if (loadEnd) begin
                    stateD = scbr_pkg::HOST_FINISH;
                end
            end
            scbr_pkg::HOST_FINISH: begin
                stateD = CLEAR_AFTER ? scbr_pkg::HOST_CLEAR
                                     : scbr_pkg::HOST_IDLE;
            end
            scbr_pkg::HOST_CLEAR: begin
                if (rstEnd) begin
                    stateD = scbr_pkg::HOST_IDLE;
                end
            end
        endcase
    end

    // ********************************************************
    // state, counters and link drive
    // ********************************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ <= scbr_pkg::HOST_IDLE;
            rstCntQ <= '0;
            halfCntQ <= '0;
            bitCntQ <= '0;
        end else begin
            stateQ <= stateD;
            rstCntQ <= (stateD != stateQ) ? '0 : rstCntQ + RW'(1);
            halfCntQ <= (halfEnd || stateQ != scbr_pkg::HOST_LOAD)
                ? '0 : halfCntQ + HW'(1);
            if (stateQ == scbr_pkg::HOST_RESET) begin
                bitCntQ <= '0;
            end else if (riseNow) begin
                bitCntQ <= bitCntQ + CW'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clkQ <= scbr_pkg::CFG_CLK_RESET;
            selNQ <= scbr_pkg::SELECT_N_RESET;
            rstNQ <= scbr_pkg::RESET_OE_N_RESET;
        end else begin
            clkQ <= (stateD == scbr_pkg::HOST_LOAD) & (clkQ ^ halfEnd);
            selNQ <= (stateD != scbr_pkg::HOST_LOAD);
            rstNQ <= (stateD != scbr_pkg::HOST_RESET)
                   & (stateD != scbr_pkg::HOST_CLEAR);
        end
    end

    // capture happens in the cycle the clock is raised: the bit
    // presented before this rising edge belongs to it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bitValidQ <= 1'b0;
            bitDataQ <= 1'b0;
            doneQ <= 1'b0;
        end else begin
            bitValidQ <= riseNow;
            if (riseNow) begin
                bitDataQ <= link.fpgaSerialDataIn;
            end
            doneQ <= (stateQ != scbr_pkg::HOST_IDLE)
                   & (stateD == scbr_pkg::HOST_IDLE);
        end
    end

    assign link.configClock = clkQ;
    assign link.fpgaConfigSelectN = selNQ;
    assign link.resetOeN = rstNQ;
    assign link.serialProgramSelectN = 1'b1;

    assign busy = (stateQ != scbr_pkg::HOST_IDLE);
    assign loadDone = doneQ;
    assign bitValid = bitValidQ;
    assign bitData = bitDataQ;
    assign bitCount = bitCntQ;

endmodule

// *** verification/scbr_link_properties.sv ***
// concurrent checks on the link between memory and loader
`timescale 1ns/1ps
module scbr_link_properties (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // link wires
    input wire logic configClock,
    input wire logic resetOeN,
    input wire logic fpgaConfigSelectN,
    input wire logic serialProgramSelectN,
    input wire logic dataOut,
    input wire logic dataOe,
    input wire logic cascadeSelectOutN
);
    // ********************************************************
    // link properties
    // ********************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    wire logic enabled = resetOeN && !fpgaConfigSelectN
        && serialProgramSelectN && cascadeSelectOutN;

    oe_reset_off_a: assert property (!resetOeN |=> !dataOe)
        else $error("driver on during counter reset");
    oe_deselect_a: assert property (fpgaConfigSelectN |=> !dataOe)
        else $error("driver on while deselected");
    oe_enable_a: assert property (enabled ##1 cascadeSelectOutN
        |-> dataOe)
        else $error("driver off while selected");
    oe_done_off_a: assert property ($fell(cascadeSelectOutN)
        |-> !dataOe)
        else $error("driver on after last bit");
    // data may only move two cycles after a clock rise
    data_step_a: assert property (dataOe && $past(dataOe)
        && $changed(dataOut)
        |-> $past(configClock, 2) && !$past(configClock, 3))
        else $error("data moved without a clock rise");
    cascade_hold_a: assert property (!cascadeSelectOutN && resetOeN
        && $past(resetOeN) |=> !cascadeSelectOutN)
        else $error("cascade released without reset");
    cascade_clear_a: assert property (!resetOeN [*3]
        |-> cascadeSelectOutN)
        else $error("cascade not cleared by reset");
    prog_sel_a: assert property (serialProgramSelectN)
        else $error("programming select driven low");
    // 12 cycles at 5 ns cover the 60 ns minimum
    reset_pulse_a: assert property ($fell(resetOeN)
        |=> !resetOeN [*8] ##1 !resetOeN [*3])
        else $error("counter reset pulse too short");
endmodule

// *** verification/tb_serial_config_bitstream_readout.sv ***
// self-checking bench: loader, memory and cascaded second memory
`timescale 1ns/1ps
module tb_serial_config_bitstream_readout;
    // ********************************************************
    // stimulus and wiring
    // ********************************************************
    localparam int NB = 16;
    logic sys_clk = 1'h0;
    logic rst_n = 1'h0;
    logic loadEnA = 1'h0;
    logic loadEnB = 1'h0;
    logic [3:0] loadAddr = 4'h0;
    logic loadData = 1'h0;
    logic startReq = 1'h0;
    logic busy, loadDone, bitValid, bitData;
    logic [4:0] bitCount;
    logic [3:0] readAddrA;
    logic activeA, activeB, endedA;
    int numErrors = 0;
    int checkCount = 0;

    scbr_link_if linkA();
    scbr_link_if linkB();
    // second memory sees the first one's cascade as its select
    assign linkB.configClock = linkA.configClock;
    assign linkB.resetOeN = linkA.resetOeN;
    assign linkB.fpgaConfigSelectN = linkA.cascadeSelectOutN;
    assign linkB.serialProgramSelectN = linkA.serialProgramSelectN;

    scbr_memory #(.MEM_BITS(NB)) i_scbr_memory (.sys_clk(sys_clk),
        .rst_n(rst_n), .link(linkA), .loadEn(loadEnA), .loadAddr(loadAddr),
        .loadData(loadData), .readAddr(readAddrA), .readoutActive(activeA),
        .readoutEnded(endedA));
    scbr_memory #(.MEM_BITS(NB)) i_scbr_memory_b (.sys_clk(sys_clk),
        .rst_n(rst_n), .link(linkB), .loadEn(loadEnB), .loadAddr(loadAddr),
        .loadData(loadData), .readAddr(), .readoutActive(activeB),
        .readoutEnded());
    // two extra bits read the released line after the first memory ends
    scbr_loader #(.LOAD_BITS(NB + 2)) i_scbr_loader (.sys_clk(sys_clk),
        .rst_n(rst_n), .link(linkA), .startReq(startReq), .busy(busy),
        .loadDone(loadDone), .bitValid(bitValid), .bitData(bitData),
        .bitCount(bitCount));
    scbr_link_properties i_scbr_link_properties (.sys_clk(sys_clk),
        .rst_n(rst_n), .configClock(linkA.configClock),
        .resetOeN(linkA.resetOeN),
        .fpgaConfigSelectN(linkA.fpgaConfigSelectN),
        .serialProgramSelectN(linkA.serialProgramSelectN),
        .dataOut(linkA.dataOut), .dataOe(linkA.dataOe),
        .cascadeSelectOutN(linkA.cascadeSelectOutN));

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ********************************************************
    // tasks
    // ********************************************************
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            numErrors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checkCount, numErrors);
        if (numErrors == 0 && checkCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic store(input logic toB, input logic [NB-1:0] pat);
        for (int i = 0; i < NB; i++) begin
            @(posedge sys_clk);
            #1;
            loadEnA = !toB;
            loadEnB = toB;
            loadAddr = 4'(i);
            loadData = pat[i];
        end
        @(posedge sys_clk);
        #1;
        loadEnA = 1'h0;
        loadEnB = 1'h0;
    endtask

    // one full readout; released line reads back as idle ones
    task automatic readout(input logic [NB-1:0] pat);
        logic [NB+1:0] got;
        int n;
        int t;
        int ends;
        logic sawCasc;
        logic sawB;
        got = '0;
        n = 0;
        ends = 0;
        sawCasc = 1'h0;
        sawB = 1'h0;
        @(posedge sys_clk);
        #1 startReq = 1'h1;
        @(posedge sys_clk);
        #1 startReq = 1'h0;
        for (t = 0; t < 1000 && loadDone !== 1'h1; t++) begin
            @(posedge sys_clk);
            #1;
            if (bitValid === 1'h1 && n < NB + 2) begin
                got[n] = bitData;
                n++;
            end
            if (linkA.cascadeSelectOutN === 1'h0) sawCasc = 1'h1;
            if (activeB === 1'h1) sawB = 1'h1;
            if (endedA === 1'h1) ends++;
        end
        if (t >= 1000) begin
            numErrors++;
            tally_and_finish();
        end
        check("bits", {14'h0, 2'h3, pat}, 32'(got));
        check("bit total", NB + 2, n);
        check("cascade low", 32'h1, 32'(sawCasc));
        check("next enabled", 32'h1, 32'(sawB));
        check("addr cleared", 32'h0, 32'(readAddrA));
        check("cascade back", 32'h1, 32'(linkA.cascadeSelectOutN));
        check("driver off", 32'h0, 32'(activeA));
        check("end pulses", 32'h1, ends);
        check("bits counted", NB + 2, 32'(bitCount));
        check("select released", 32'h1, 32'(linkA.fpgaConfigSelectN));
        check("loader idle", 32'h0, 32'(busy));
    endtask

    // ********************************************************
    // main sequence
    // ********************************************************
    initial begin
        repeat (3) @(posedge sys_clk);
        #1 rst_n = 1'h1;
        check("addr at start", 32'h0, 32'(readAddrA));
        check("cascade at start", 32'h1, 32'(linkA.cascadeSelectOutN));
        check("driver at start", 32'h0, 32'(activeA));
        store(1'h0, 16'hA5C3);
        store(1'h1, 16'h0FF0);
        readout(16'hA5C3);
        store(1'h0, 16'h3C5A);
        readout(16'h3C5A);
        tally_and_finish();
    end
endmodule
